// ==== design/pds_defines.svh ====
// Purpose: constants of the phase-step controller and its register map
// Assumes: byte addresses on a 32-bit AHB-Lite bus, 200 MHz clock
// Notes:   definitions only
`ifndef PDS_DEFINES_SVH
`define PDS_DEFINES_SVH

// register byte offsets (low 12 address bits)
`define PDS_OFF_CNT        12'h000
`define PDS_OFF_KDIV       12'h024
`define PDS_OFF_STATUS     12'h028
`define PDS_OFF_TAPS       12'h02C

// counter setting word layout and reset values
`define PDS_WORD_W         9
`define PDS_BYPASS_BIT     8
`define PDS_CNT_WORD_RST   9'h100
`define PDS_KDIV_RST       1'b0
`define PDS_FACTOR_ONE     9'h001

// status field positions
`define PDS_ST_DONE        0
`define PDS_ST_BUSY        1
`define PDS_ST_SEL_LSB     4
`define PDS_ST_UP          8
`define PDS_ST_BADSEL      9

// target select codes
`define PDS_SEL_ALL        4'h0
`define PDS_SEL_FB         4'h1
`define PDS_SEL_LAST       4'h8

// phase tap width: eight taps per vco period
`define PDS_TAP_W          3

// completion-flag low time
`define PDS_CLK_MHZ        200
`define PDS_COMPLETE_LOW_NS 10
`define PDS_COMPLETE_LOW_CYC ((`PDS_COMPLETE_LOW_NS * `PDS_CLK_MHZ + 999) / 1000)

`endif

// ==== design/pds_pkg.sv ====
// Purpose: types shared by the phase-step controller
// Assumes: nothing
// Notes:   constants live in pds_defines.svh
package pds_pkg;

  typedef enum logic [1:0] {PDS_IDLE, PDS_ARMED, PDS_SHIFT} pds_state_e;

  // one latched step order
  typedef struct packed {
    logic       up;
    logic [3:0] sel;
  } pds_step_s;

  // one captured bus address phase
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
  } pds_ahb_req_s;

endpackage : pds_pkg

// ==== design/pds_cnt_word.sv ====
// Purpose: decode one nine-bit counter setting word into bypass and factor
// Assumes: word comes from a register on the same clock
// Notes:   factor is the low byte unless bypassed
`include "pds_defines.svh"
module pds_cnt_word (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [8:0] word_i,
  output logic            bypass_o,
  output logic [8:0]      factor_o
);

  // bypass forces a factor of one and ignores the value bits
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      bypass_o <= 1'b1;
      factor_o <= `PDS_FACTOR_ONE;
    end
    else
    begin
      bypass_o <= word_i[`PDS_BYPASS_BIT];
      factor_o <= word_i[`PDS_BYPASS_BIT] ? `PDS_FACTOR_ONE : {1'b0, word_i[7:0]};
    end
  end

  AST_BYPASS_ONE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    word_i[`PDS_BYPASS_BIT] |=> bypass_o && factor_o == `PDS_FACTOR_ONE)
    else $error("bypassed counter not at factor one");

  AST_NORMAL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !word_i[`PDS_BYPASS_BIT] |=> !bypass_o && factor_o[7:0] == $past(word_i[7:0]))
    else $error("counter bypassed while bit clear");

endmodule : pds_cnt_word

// ==== design/pds_phase_tap.sv ====
// Purpose: vco phase-tap selection of one counter
// Assumes: step_i is a one-cycle pulse
// Notes:   the tap wraps, so eight steps return to the same phase
module pds_phase_tap #(
  parameter int TAP_W = 3
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             step_i,
  input  wire logic             up_i,
  output logic [TAP_W-1:0]      tap_o
);

  // one tap position is one eighth of the vco period
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      tap_o <= '0;
    else if (step_i)
      tap_o <= up_i ? tap_o + 1'b1 : tap_o - 1'b1;
  end

  AST_ONE_TAP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    step_i |=> (tap_o == TAP_W'($past(tap_o) + 1'b1)) == $past(up_i)
            && (tap_o == TAP_W'($past(tap_o) - 1'b1)) == !$past(up_i))
    else $error("tap did not move by exactly one position");

endmodule : pds_phase_tap

// ==== design/pds_top.sv ====
// Purpose: dynamic phase-step controller with counter setting registers
// Assumes: CLK_I is the free-running reconfiguration clock; step pins come
//          from logic on that clock; AHB-Lite word accesses only
// Notes:   zero-wait-state slave; responses always OKAY
//
// Contract
// - a bypassed counter applies a factor of exactly one.
// - bit 8 of a counter word set to 1 bypasses it and ignores other bits, 0 runs it.
// - the vco post-scale divider is bypassed when its single bit is 0.
// - each step moves the selected taps by one position, one eighth of a vco period.
// - outputs keep running during a step, and stepping needs no scan-chain load.
// - target select and direction are captured on rising clock edges.
// - direction high shifts later, low shifts earlier.
// - the step request is sampled on the falling clock edge.
// - on the second rising edge after sampling, direction and select are latched and
//         shifting starts.
// - on that edge the done flag drops and stays low until shifting ends.
`include "pds_defines.svh"
module pds_top #(
  parameter int NCNT  = 9,
  parameter int NTAP  = 8,
  parameter int TAP_W = `PDS_TAP_W
) (
  input  wire logic                   CLK_I,
  input  wire logic                   RESET_N_I,
  input  wire logic                   HSEL_I,
  input  wire logic [31:0]            HADDR_I,
  input  wire logic [1:0]             HTRANS_I,
  input  wire logic                   HWRITE_I,
  input  wire logic [2:0]             HSIZE_I,
  input  wire logic [31:0]            HWDATA_I,
  input  wire logic                   HREADY_I,
  output logic [31:0]                 HRDATA_O,
  output logic                        HREADYOUT_O,
  output logic                        HRESP_O,
  input  wire logic                   STEP_I,
  input  wire logic                   UPDOWN_I,
  input  wire logic [3:0]             CNTSEL_I,
  output logic                        DONE_O,
  output logic [NTAP*TAP_W-1:0]       PHASE_TAP_O,
  output logic [NCNT-1:0]             CNT_BYPASS_O,
  output logic                        VCO_DIV_BYPASS_O
);

  // the low-time count below rounds the settling time up to whole clock cycles
  localparam logic [7:0] LOWC8 = 8'(`PDS_COMPLETE_LOW_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: address phase capture
  ////////////////////////////////////////////////////////////////////////////

  pds_pkg::pds_ahb_req_s req_r;
  logic                  wr_pend_r;
  logic [8:0]            cnt_word_r [NCNT];
  logic                  kdiv_r;
  logic [8:0]            fac_w [NCNT];
  logic [31:0]           status_w;
  logic [31:0]           taps_w;
  logic [31:0]           rd_mux_w;

  // a transfer is taken only when selected, non-idle and the bus is ready
  wire        addr_ok_w  = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire [11:0] addr_w     = HADDR_I[11:0];
  wire [3:0]  ridx_w     = HADDR_I[5:2];
  wire        rd_cnt_w   = addr_w < `PDS_OFF_KDIV;
  wire [3:0]  widx_w     = req_r.addr[5:2];
  wire        wr_cnt_w   = wr_pend_r & (req_r.addr < `PDS_OFF_KDIV);
  wire        wr_kdiv_w  = wr_pend_r & (req_r.addr == `PDS_OFF_KDIV);

  // hsize is not checked: only whole-word transfers are supported
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      wr_pend_r <= 1'b0;
      req_r     <= '0;
    end
    else
    begin
      wr_pend_r <= addr_ok_w & HWRITE_I;
      if (addr_ok_w)
        req_r <= '{wr: HWRITE_I, addr: addr_w};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter setting words and vco divider bit
  ////////////////////////////////////////////////////////////////////////////

  // writes land in the data phase, one word per register
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      for (int i = 0; i < NCNT; i++)
        cnt_word_r[i] <= `PDS_CNT_WORD_RST;
      kdiv_r <= `PDS_KDIV_RST;
    end
    else
    begin
      if (wr_cnt_w)
        cnt_word_r[widx_w] <= HWDATA_I[8:0];
      if (wr_kdiv_w)
        kdiv_r <= HWDATA_I[0];
    end
  end

  // inverted polarity: a clear bit bypasses the post-scale divider
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      VCO_DIV_BYPASS_O <= 1'b1;
    else
      VCO_DIV_BYPASS_O <= ~kdiv_r;
  end

  // one decoder per counter word: n, m, then the seven output counters
  for (genvar g = 0; g < NCNT; g++)
  begin : g_word
    pds_cnt_word u_word (
      .clk_i     (CLK_I),
      .reset_n_i (RESET_N_I),
      .word_i    (cnt_word_r[g]),
      .bypass_o  (CNT_BYPASS_O[g]),
      .factor_o  (fac_w[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // step request sampling and sequencing
  ////////////////////////////////////////////////////////////////////////////

  pds_pkg::pds_state_e state_r;
  pds_pkg::pds_state_e state_nxt;
  pds_pkg::pds_step_s  last_r;
  logic                step_neg_r;
  logic                step_seen_r;
  logic [7:0]          low_cnt_r;
  logic                bad_sel_r;

  // falling-edge sample keeps the request away from the rising-edge captures
  always_ff @(negedge CLK_I)
  begin
    if (!RESET_N_I)
      step_neg_r <= 1'b0;
    else
      step_neg_r <= STEP_I;
  end

  // a rise of the sampled level is one request, however long it stays high
  wire new_req_w = step_neg_r & ~step_seen_r;
  wire fire_w    = (state_r == pds_pkg::PDS_ARMED);

  // next state: armed on the first rising edge, shifting on the second
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      pds_pkg::PDS_IDLE:  if (new_req_w) state_nxt = pds_pkg::PDS_ARMED;
      pds_pkg::PDS_ARMED: state_nxt = pds_pkg::PDS_SHIFT;
      pds_pkg::PDS_SHIFT: if (low_cnt_r <= 8'h01) state_nxt = pds_pkg::PDS_IDLE;
    endcase
  end

  // requests arriving while busy are dropped; the controller must wait
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      state_r     <= pds_pkg::PDS_IDLE;
      step_seen_r <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      step_seen_r <= step_neg_r;
    end
  end

  // latch order and start shifting on the second rising edge
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      last_r    <= '0;
      bad_sel_r <= 1'b0;
    end
    else if (fire_w)
    begin
      last_r    <= '{up: UPDOWN_I, sel: CNTSEL_I};
      bad_sel_r <= CNTSEL_I > `PDS_SEL_LAST;
    end
  end

  // done low time stands for internal settling, counted apart from the request
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      DONE_O    <= 1'b1;
      low_cnt_r <= 8'h00;
    end
    else if (fire_w)
    begin
      DONE_O    <= 1'b0;
      low_cnt_r <= LOWC8;
    end
    else if (state_r == pds_pkg::PDS_SHIFT)
    begin
      low_cnt_r <= low_cnt_r - 8'h01;
      if (low_cnt_r <= 8'h01)
        DONE_O <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // target decode and phase taps
  ////////////////////////////////////////////////////////////////////////////

  logic [NTAP-1:0] hit_w;

  // tap 0 is the feedback counter, taps 1 to 7 the output counters
  assign hit_w[0] = (CNTSEL_I == `PDS_SEL_FB);
  for (genvar t = 1; t < NTAP; t++)
  begin : g_hit
    // codes above the last output counter match nothing
    assign hit_w[t] = (CNTSEL_I == `PDS_SEL_ALL) || (CNTSEL_I == 4'(t + 1));
  end

  // only the tap selection moves; counters and outputs run on undisturbed
  for (genvar t = 0; t < NTAP; t++)
  begin : g_tap
    pds_phase_tap #(.TAP_W(TAP_W)) u_tap (
      .clk_i     (CLK_I),
      .reset_n_i (RESET_N_I),
      .step_i    (fire_w & hit_w[t]),
      .up_i      (UPDOWN_I),
      .tap_o     (PHASE_TAP_O[t*TAP_W +: TAP_W])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: read data and response
  ////////////////////////////////////////////////////////////////////////////

  // status shows the sequencer and the last order taken
  assign status_w = {22'h000000, bad_sel_r, last_r.up, last_r.sel, 2'b00,
                     (state_r != pds_pkg::PDS_IDLE), DONE_O};
  assign taps_w   = {{(32 - NTAP*TAP_W){1'b0}}, PHASE_TAP_O};

  // counter words read back with their effective factor in bits 24:16
  assign rd_mux_w = (rd_cnt_w && ridx_w < 4'(NCNT))
                      ? {7'h00, fac_w[ridx_w], 7'h00, cnt_word_r[ridx_w]}
                  : (addr_w == `PDS_OFF_KDIV)   ? {31'h00000000, kdiv_r}
                  : (addr_w == `PDS_OFF_STATUS) ? status_w
                  : (addr_w == `PDS_OFF_TAPS)   ? taps_w
                  : 32'h00000000;

  // read data is prepared in the address phase so no wait state is needed
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      HRDATA_O    <= 32'h00000000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
    else
    begin
      if (addr_ok_w && !HWRITE_I)
        HRDATA_O <= rd_mux_w;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  ////////////////////////////////////////////////////////////////////////////

  AST_ARM_ON_RISE: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_IDLE && step_neg_r && !step_seen_r
      |=> state_r == pds_pkg::PDS_ARMED ##1 !DONE_O)
    else $error("sampled request did not start a step two edges later");

  AST_DONE_DROP: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED && DONE_O |=> $fell(DONE_O))
    else $error("done did not drop when shifting started");

  // two cycles is the low time at the 200 MHz clock; retune if the header changes
  AST_DONE_LOW: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    $fell(DONE_O) |-> (!DONE_O && state_r == pds_pkg::PDS_SHIFT)[*2] ##1 DONE_O)
    else $error("done low time is wrong");

  AST_LATCH: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED |=> last_r == {$past(UPDOWN_I), $past(CNTSEL_I)})
    else $error("direction or select not latched at step start");

  AST_BAD_SEL: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED && CNTSEL_I > `PDS_SEL_LAST |=> $stable(PHASE_TAP_O))
    else $error("undefined select moved a tap");

  AST_SEL_FB: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED && CNTSEL_I == `PDS_SEL_FB
      |=> $stable(PHASE_TAP_O[NTAP*TAP_W-1:TAP_W]) && !$stable(PHASE_TAP_O[TAP_W-1:0]))
    else $error("feedback select did not move only the feedback tap");

  AST_SEL_ALL: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED && CNTSEL_I == `PDS_SEL_ALL
      |=> $stable(PHASE_TAP_O[TAP_W-1:0]) && !$stable(PHASE_TAP_O[2*TAP_W-1:TAP_W]))
    else $error("all-outputs select moved the feedback tap");

  AST_DIR_UP: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED && UPDOWN_I && CNTSEL_I == `PDS_SEL_FB
      |=> PHASE_TAP_O[TAP_W-1:0] == TAP_W'($past(PHASE_TAP_O[TAP_W-1:0]) + 1'b1))
    else $error("up step did not advance the tap");

  AST_TAP_QUIET: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r != pds_pkg::PDS_ARMED |=> $stable(PHASE_TAP_O)
      && ($stable(CNT_BYPASS_O[0]) || $past(wr_cnt_w, 2)))
    else $error("tap or counter setting moved without a step or write");

  AST_KDIV: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    !kdiv_r |=> VCO_DIV_BYPASS_O)
    else $error("post-scale divider not bypassed for a clear bit");

  COV_STEP_UP: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED && UPDOWN_I ##1 !DONE_O ##[1:8] DONE_O);
  COV_STEP_DOWN: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED && !UPDOWN_I);
  COV_STEP_ALL: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED && CNTSEL_I == `PDS_SEL_ALL);
  COV_BAD_SEL: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
    state_r == pds_pkg::PDS_ARMED && CNTSEL_I > `PDS_SEL_LAST);

endmodule : pds_top

// ==== bench/pds_step_model.sv ====
// Purpose: core-side controller model issuing phase step requests
// Assumes: runs on the reconfiguration clock, one order at a time
// Notes:   measures when done fell and how many cycles it stayed low
module pds_step_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic       up_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [3:0] hold_i,
  input  wire logic       done_i,
  output logic            step_o,
  output logic            up_o,
  output logic [3:0]      sel_o,
  output logic            busy_o,
  output logic [5:0]      lat_o,
  output logic [5:0]      low_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       done_n;
  logic [5:0] k;
  logic [5:0] lat;
  logic [5:0] low;

  // done is read mid-cycle so every rising edge sees a settled value
  always @(negedge clk_i) done_n <= done_i;

  ////////////////////////////////////////////////////////////////////////////////
  // one order: set target, hold the request, drop it, then wait for done
  initial
  begin
    step_o = 1'b0;
    up_o   = 1'b0;
    sel_o  = 4'h0;
    busy_o = 1'b0;
    lat_o  = 6'h00;
    low_o  = 6'h00;
    forever
    begin
      @(posedge clk_i);
      if (go_i === 1'b1)
      begin
        busy_o <= 1'b1;
        up_o   <= up_i;
        sel_o  <= sel_i;
        step_o <= 1'b1;
        k      = 6'h00;
        lat    = 6'h00;
        low    = 6'h00;
        do
        begin
          @(posedge clk_i);
          k = k + 6'h01;
          if (k == {2'b00, hold_i})
            step_o <= 1'b0;
          if (done_n === 1'b0)
          begin
            low = low + 6'h01;
            if (lat == 6'h00)
              lat = k;
          end
        end
        while (!(k >= {2'b00, hold_i} && low != 6'h00 && done_n === 1'b1) && k < 6'h28);
        lat_o  <= lat;
        low_o  <= low;
        // stale target lines flip, so a late latch in the device shows up
        up_o   <= ~up_o;
        sel_o  <= ~sel_o;
        busy_o <= 1'b0;
      end
    end
  end
endmodule : pds_step_model

// ==== bench/pll_dynamic_phase_shift_bench.sv ====
// Purpose: self-checking bench of the phase-step controller
// Assumes: zero-wait AHB-Lite slave, step orders from the controller model
// Notes:   expected taps are kept in a bench-side model of eight counters
`include "pds_defines.svh"
module pll_dynamic_phase_shift_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FALL_EDGE = 3; // done seen low one edge after the latching edge
  logic        CLK_I, RESET_N_I, HSEL_I, HWRITE_I, HREADYOUT_O, HRESP_O;
  logic        STEP_I, UPDOWN_I, DONE_O, VCO_DIV_BYPASS_O;
  logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, rd;
  logic [1:0]  HTRANS_I;
  logic [3:0]  CNTSEL_I, sel, hold;
  logic [23:0] PHASE_TAP_O;
  logic [8:0]  CNT_BYPASS_O;
  logic        go, up, busy;
  logic [5:0]  lat, low;
  logic [2:0]  exp_tap [8];
  int          fail_count, cmp_count, i, s;

  pds_top dut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2), .HWDATA_I(HWDATA_I),
    .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
    .HRESP_O(HRESP_O), .STEP_I(STEP_I), .UPDOWN_I(UPDOWN_I), .CNTSEL_I(CNTSEL_I),
    .DONE_O(DONE_O), .PHASE_TAP_O(PHASE_TAP_O), .CNT_BYPASS_O(CNT_BYPASS_O),
    .VCO_DIV_BYPASS_O(VCO_DIV_BYPASS_O));

  pds_step_model ctl (.clk_i(CLK_I), .go_i(go), .up_i(up), .sel_i(sel), .hold_i(hold),
    .done_i(DONE_O), .step_o(STEP_I), .up_o(UPDOWN_I), .sel_o(CNTSEL_I), .busy_o(busy),
    .lat_o(lat), .low_o(low));

  // 200 MHz clock
  initial
  begin
    CLK_I = 1'b0;
    forever #2.5 CLK_I = ~CLK_I;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one single AHB-Lite transfer; waits have no limit of their own, the watchdog ends a hang
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    HSEL_I   <= 1'b1;
    HTRANS_I <= 2'h2;
    HADDR_I  <= a;
    HWRITE_I <= wr;
    do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
    HTRANS_I <= 2'h0;
    HWDATA_I <= wd;
    do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
    rd = HRDATA_O;
    chk({31'h0, HRESP_O}, 32'h0, "response");
  endtask : ahb

  // one idle edge first, so a read never follows its own write directly
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    @(posedge CLK_I);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rd_chk

  function automatic logic [23:0] taps_exp();
    logic [23:0] t;
    for (int j = 0; j < 8; j++) t[j*3 +: 3] = exp_tap[j];
    return t;
  endfunction : taps_exp

  // one step through the controller model, then model update and compares
  task automatic run(input logic [3:0] ts, input logic tu, input logic [3:0] th);
    int n;
    go   <= 1'b1;
    sel  <= ts;
    up   <= tu;
    hold <= th;
    @(posedge CLK_I);
    go <= 1'b0;
    n = 0;
    do begin @(posedge CLK_I); n++; end while (busy !== 1'b0 && n < 60);
    chk({31'h0, busy}, 32'h0, "controller idle");
    for (int j = 0; j < 8; j++)
      if ((ts == 4'h0 && j > 0) || (ts >= 4'h1 && ts <= 4'h8 && j == ts - 1))
        exp_tap[j] = tu ? exp_tap[j] + 3'h1 : exp_tap[j] - 3'h1;
    chk(PHASE_TAP_O, taps_exp(), "taps");
    chk(lat, FALL_EDGE, "done fall");
    chk(low, `PDS_COMPLETE_LOW_CYC, "done low cycles");
  endtask : run

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs a few hundred cycles
  initial
  begin
    #60000;
    fail_count++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    fail_count = 0;
    cmp_count  = 0;
    RESET_N_I  = 1'b0;
    HSEL_I     = 1'b0;
    HADDR_I    = 32'h0;
    HTRANS_I   = 2'h0;
    HWRITE_I   = 1'b0;
    HWDATA_I   = 32'h0;
    go         = 1'b0;
    up         = 1'b0;
    sel        = 4'h0;
    hold       = 4'h2;
    for (i = 0; i < 8; i++) exp_tap[i] = 3'h0;
    repeat (4) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    @(posedge CLK_I);
    chk({31'h0, DONE_O}, 32'h1, "done idle");
    chk({31'h0, HREADYOUT_O}, 32'h1, "ready idle");
    chk(PHASE_TAP_O, 24'h0, "taps reset");
    chk(CNT_BYPASS_O, 9'h1FF, "bypass reset");
    chk({31'h0, VCO_DIV_BYPASS_O}, 32'h1, "post-scale reset");
    for (i = 0; i < 9; i++) rd_chk(4 * i, 32'h0001_0100, "word reset");
    rd_chk(`PDS_OFF_KDIV, 32'h0, "kdiv reset");
    $display("test reset values finished");
    // counter words: running value, then bypass with junk in the value field
    for (i = 0; i < 9; i++)
    begin
      ahb(1'b1, 4 * i, 32'h0000_0010 + i);
      rd_chk(4 * i, 32'h0010_0010 + (i << 16) + i, "word run");
      chk(CNT_BYPASS_O[i], 1'b0, "bypass off");
      ahb(1'b1, 4 * i, 32'h0000_01A5);
      rd_chk(4 * i, 32'h0001_01A5, "word bypass");
      chk(CNT_BYPASS_O[i], 1'b1, "bypass on");
    end
    ahb(1'b1, `PDS_OFF_KDIV, 32'h1);
    rd_chk(`PDS_OFF_KDIV, 32'h1, "kdiv set");
    chk({31'h0, VCO_DIV_BYPASS_O}, 32'h0, "post-scale run");
    ahb(1'b1, `PDS_OFF_KDIV, 32'h0);
    rd_chk(`PDS_OFF_KDIV, 32'h0, "kdiv clear");
    chk({31'h0, VCO_DIV_BYPASS_O}, 32'h1, "post-scale bypass");
    ahb(1'b1, 32'h40, 32'hFFFF_FFFF);
    rd_chk(32'h40, 32'h0, "unmapped");
    $display("test registers finished");
    // every select code once upward, with status readback
    for (s = 0; s < 16; s++)
    begin
      run(s, 1'b1, 4'h2);
      rd_chk(`PDS_OFF_STATUS, ((s > 8) << 9) + 32'h101 + (s << 4), "status");
    end
    $display("test select codes finished");
    // downward steps through the wrap, a long request and back-to-back orders
    for (s = 0; s < 9; s++) run(s, 1'b0, 4'h2);
    for (i = 0; i < 3; i++) run(4'h1, 1'b0, 4'h2);
    run(4'h5, 1'b1, 4'h6);
    rd_chk(`PDS_OFF_TAPS, {8'h0, taps_exp()}, "taps register");
    chk({31'h0, DONE_O}, 32'h1, "done after run");
    $display("test steps finished");
    print_verdict();
  end
endmodule : pll_dynamic_phase_shift_bench
